// *** rtl/rcd_pkg.sv ***
package rcd_pkg;

	// register map, byte addresses on the apb bus
	localparam logic [7:0] RCD_CTRL_OFFSET = 8'h00;
	localparam logic [7:0] RCD_STATUS_OFFSET = 8'h04;

	// control register value after any reset: slew limit on, 50% duty, undivided
	localparam logic [7:0] RCD_CTRL_RESET = 8'h30;

	// control field positions
	localparam int RCD_EN_BIT = 7;
	localparam int RCD_OE_BIT = 6;
	localparam int RCD_SLEW_BIT = 5;
	localparam int RCD_DUTY_LSB = 3;
	localparam int RCD_DIV_LSB = 0;

	// status field positions
	localparam int RCD_ST_RUN_BIT = 0;
	localparam int RCD_ST_WAVE_BIT = 1;
	localparam int RCD_ST_PIN_OE_BIT = 2;
	localparam int RCD_ST_PIN_CPU_BIT = 3;
	localparam int RCD_ST_SLEEP_BIT = 4;

	// codes of the divider and duty fields
	localparam logic [2:0] RCD_DIV_UNDIVIDED = 3'h0;
	localparam logic [2:0] RCD_DIV_BY_TWO = 3'h1;
	localparam logic [1:0] RCD_DUTY_ZERO = 2'h0;

	// divider counter width covers the largest ratio of 128
	localparam int RCD_CNT_W = 7;

	typedef struct packed {
		logic en;
		logic oe;
		logic slew;
		logic [1:0] duty;
		logic [2:0] div;
	} rcd_ctrl_t;

	typedef enum logic [1:0] {
		RCD_OFF,
		RCD_RUN,
		RCD_FROZEN
	} rcd_state_t;

endpackage : rcd_pkg

// *** rtl/rcd_top.sv ***
// Behaviour
// RQ1: reference clock is derived only from pclk, the system clock.
// RQ2: generator runs only while the module enable bit 7 is set.
// RQ3: pin is driven with the reference clock only while bit 6 is set.
// RQ4: divider code 000 passes base clock, codes 001..111 divide by 2..128.
// RQ5: duty field selects 75, 50, 25 or 0 percent; 0 percent is constant low.
// RQ6: undivided mode passes source duty cycle, except 0 percent still forces low.
// RQ7: divide-by-two 25 and 75 percent accuracy depends on source clock.
// RQ8: slew limit output follows bit 5 of the control register.
// RQ9: any reset disables the module and restores the control register default.
// RQ10: crystal oscillator modes take the pin; reference clock is not driven there.
// RQ11: cpu clock-out config at 0 puts the instruction clock on the pin.
// RQ12: module still runs and feeds the modulator when the pin is unavailable.
// RQ13: sleep stops generation and holds outputs at their current levels; in undivided mode the clock goes to the held wave level half a cycle later.
// RQ14: disabled module holds its clock low and the counter cleared.
//
// Our own choices: the APB interface to the registers and the register addresses.
module rcd_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device configuration and power state
	input wire logic cpu_clock_out_config,
	input wire logic low_power_crystal_mode,
	input wire logic crystal_mode,
	input wire logic high_speed_crystal_mode,
	input wire logic sleep,
	input wire logic instr_clock,
	// clock outputs
	output logic refclk_to_modulator,
	output logic reference_clock_pin_out,
	output logic reference_clock_pin_oe,
	output logic refclk_slew_limit_enable
);

	// register state
	rcd_pkg::rcd_ctrl_t ctrl_q, ctrl_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	// generator state
	rcd_pkg::rcd_state_t state_q, state_d;
	logic [rcd_pkg::RCD_CNT_W-1:0] cnt_q, cnt_d;
	logic wave_q, wave_d;
	logic neg_q;
	// pin state
	logic pin_oe_q, pin_oe_d;
	logic pin_cpu_q, pin_cpu_d;
	logic instr_q;
	logic slew_q;
	// helpers
	logic crystal;
	logic setup;
	logic [rcd_pkg::RCD_CNT_W-1:0] mask;
	logic [rcd_pkg::RCD_CNT_W-1:0] high;
	logic refclk;

	// decode of one register address, used by read and write paths
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction : hit

	// last period position for a divider code, 2**code - 1
	function automatic logic [rcd_pkg::RCD_CNT_W-1:0] period_mask(input logic [2:0] code);
		period_mask = 7'((8'h01 << code) - 8'h01);
	endfunction : period_mask

	assign crystal = low_power_crystal_mode | crystal_mode | high_speed_crystal_mode;
	assign setup = psel & ~penable;
	assign mask = period_mask(ctrl_q.div);

	// high time in cycles: ratio * duty / 4, at least one cycle; the divide-by-two
	// 25 and 75 percent settings round to one cycle since only rising edges count
	always_comb begin
		logic [9:0] prod;
		prod = 10'h000;
		prod = 10'({3'h0, mask} + 10'h001) * 10'({8'h00, ctrl_q.duty});
		high = 7'(prod >> 2);
		if (high == 7'h00) begin
			high = 7'h01; // RQ7
		end
	end

	// apb next values: writes act in the access cycle, reads are captured at setup
	always_comb begin
		ctrl_d = ctrl_q;
		prdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		if (setup) begin
			pready_d = 1'b1;
			prdata_d = 32'h0000_0000;
			if (hit(paddr, rcd_pkg::RCD_CTRL_OFFSET)) begin
				prdata_d = {24'h00_0000, ctrl_q};
			end else if (hit(paddr, rcd_pkg::RCD_STATUS_OFFSET)) begin
				prdata_d[rcd_pkg::RCD_ST_RUN_BIT] = (state_q == rcd_pkg::RCD_RUN);
				prdata_d[rcd_pkg::RCD_ST_WAVE_BIT] = wave_q;
				prdata_d[rcd_pkg::RCD_ST_PIN_OE_BIT] = pin_oe_q;
				prdata_d[rcd_pkg::RCD_ST_PIN_CPU_BIT] = pin_cpu_q;
				prdata_d[rcd_pkg::RCD_ST_SLEEP_BIT] = (state_q == rcd_pkg::RCD_FROZEN);
			end else begin
				pslverr_d = 1'b1;
			end
		end
		if (psel & penable & pready_q & pwrite & hit(paddr, rcd_pkg::RCD_CTRL_OFFSET)) begin
			ctrl_d = pwdata[7:0];
		end
	end

	// apb registers; reset restores the control default
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= rcd_pkg::RCD_CTRL_RESET; // RQ9
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// generator next values: counter of pclk cycles shaped into the wave
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		wave_d = wave_q;
		case (state_q)
			rcd_pkg::RCD_OFF: begin
				cnt_d = 7'h00; // RQ14
				wave_d = 1'b0; // RQ14
				if (ctrl_q.en && !sleep) begin
					state_d = rcd_pkg::RCD_RUN; // RQ2
				end
			end
			rcd_pkg::RCD_RUN: begin
				if (sleep) begin
					state_d = rcd_pkg::RCD_FROZEN; // RQ13
				end else if (!ctrl_q.en) begin
					state_d = rcd_pkg::RCD_OFF; // RQ2
					cnt_d = 7'h00;
					wave_d = 1'b0;
				end else if (ctrl_q.duty == rcd_pkg::RCD_DUTY_ZERO) begin
					cnt_d = 7'h00;
					wave_d = 1'b0; // RQ5
				end else if (ctrl_q.div == rcd_pkg::RCD_DIV_UNDIVIDED) begin
					// toggling against the falling-edge copy rebuilds pclk itself
					cnt_d = 7'h00;
					wave_d = ~wave_q; // RQ6
				end else begin
					// pclk is the only time base, so the divider has no other source
					cnt_d = (cnt_q >= mask) ? 7'h00 : 7'(cnt_q + 7'h01); // RQ1 RQ4
					wave_d = (cnt_d < high); // RQ5
				end
			end
			rcd_pkg::RCD_FROZEN: begin
				// counter and wave keep their levels until sleep ends
				if (!sleep && ctrl_q.en) begin
					state_d = rcd_pkg::RCD_RUN; // RQ13
				end else if (!sleep) begin
					// disabled while asleep: wake straight into the cleared idle state
					state_d = rcd_pkg::RCD_OFF; // RQ14
					cnt_d = 7'h00;
					wave_d = 1'b0;
				end
			end
			default: begin
				state_d = rcd_pkg::RCD_OFF;
				cnt_d = 7'h00;
				wave_d = 1'b0;
			end
		endcase
	end

	// generator registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= rcd_pkg::RCD_OFF; // RQ9
			cnt_q <= 7'h00;
			wave_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			wave_q <= wave_d;
		end
	end

	// falling-edge copy: held low outside undivided mode, so the xor passes the wave
	// in divided modes and gives the source duty cycle in undivided mode
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			neg_q <= 1'b0;
		end else if (state_q == rcd_pkg::RCD_RUN && ctrl_q.div == rcd_pkg::RCD_DIV_UNDIVIDED) begin
			neg_q <= wave_q; // RQ6
		end else begin
			neg_q <= 1'b0;
		end
	end

	// modulator always sees the clock, whatever the pin is doing
	assign refclk = wave_q ^ neg_q; // RQ12

	// pin ownership: crystal modes release the pin, cpu clock-out wins over us
	always_comb begin
		pin_oe_d = 1'b0;
		pin_cpu_d = 1'b0;
		if (crystal) begin
			pin_oe_d = 1'b0; // RQ10
		end else if (!cpu_clock_out_config) begin
			pin_oe_d = 1'b1; // RQ11
			pin_cpu_d = 1'b1; // RQ11
		end else begin
			pin_oe_d = ctrl_q.en & ctrl_q.oe; // RQ3
		end
	end

	// pin registers; the instruction clock is resampled so it leaves through a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe_q <= 1'b0;
			pin_cpu_q <= 1'b0;
			instr_q <= 1'b0;
			slew_q <= 1'b1;
		end else begin
			pin_oe_q <= pin_oe_d;
			pin_cpu_q <= pin_cpu_d;
			instr_q <= instr_clock;
			slew_q <= ctrl_q.slew; // RQ8
		end
	end

	// outputs; the clock paths pass one xor gate so undivided mode can follow pclk
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign refclk_to_modulator = refclk;
	assign reference_clock_pin_out = pin_oe_q & (pin_cpu_q ? instr_q : refclk); // RQ11
	assign reference_clock_pin_oe = pin_oe_q;
	assign refclk_slew_limit_enable = slew_q;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_div_wrap: assert property ( // RQ4
		(state_q == rcd_pkg::RCD_RUN && !sleep && ctrl_q.en && ctrl_q.duty != rcd_pkg::RCD_DUTY_ZERO
			&& ctrl_q.div != rcd_pkg::RCD_DIV_UNDIVIDED && cnt_q == mask && $stable(ctrl_q))
		|=> (cnt_q == 7'h00)
	) else $error("divider counter did not wrap at end of period");

	a_count_source: assert property ( // RQ1
		(state_q == rcd_pkg::RCD_RUN && !sleep && ctrl_q.en && ctrl_q.duty != rcd_pkg::RCD_DUTY_ZERO
			&& ctrl_q.div != rcd_pkg::RCD_DIV_UNDIVIDED && cnt_q < mask && $stable(ctrl_q))
		|=> (cnt_q == 7'($past(cnt_q) + 7'h01))
	) else $error("divider counter did not advance by one per pclk");

	a_disabled_low: assert property ( // RQ2 RQ14
		(!ctrl_q.en && !sleep) [*2] |-> (wave_q == 1'b0 && cnt_q == 7'h00 && state_q == rcd_pkg::RCD_OFF)
	) else $error("disabled generator not held low and cleared");

	a_pin_release: assert property ( // RQ3
		(!ctrl_q.oe && cpu_clock_out_config) |=> !reference_clock_pin_oe
	) else $error("pin driven while output enable clear");

	a_zero_duty: assert property ( // RQ5
		(state_q == rcd_pkg::RCD_RUN && !sleep && ctrl_q.en && ctrl_q.duty == rcd_pkg::RCD_DUTY_ZERO)
		|=> (!wave_q && !refclk_to_modulator)
	) else $error("zero duty did not force the clock low");

	a_undiv_toggle: assert property ( // RQ6
		(state_q == rcd_pkg::RCD_RUN && !sleep && ctrl_q.en && ctrl_q.duty != rcd_pkg::RCD_DUTY_ZERO
			&& ctrl_q.div == rcd_pkg::RCD_DIV_UNDIVIDED) |=> (wave_q != $past(wave_q))
	) else $error("undivided mode did not follow the source clock");

	a_half_pulse: assert property ( // RQ7
		(state_q == rcd_pkg::RCD_RUN && !sleep && ctrl_q.en && ctrl_q.duty != rcd_pkg::RCD_DUTY_ZERO
			&& ctrl_q.div == rcd_pkg::RCD_DIV_BY_TWO && $stable(ctrl_q) && wave_q) |=> !wave_q
	) else $error("divide-by-two high time longer than one cycle");

	a_slew_follow: assert property ( // RQ8
		$changed(ctrl_q.slew) |-> ##1 (refclk_slew_limit_enable == $past(ctrl_q.slew))
	) else $error("slew limit output did not follow control bit");

	a_crystal_pin: assert property ( // RQ10
		crystal |=> !reference_clock_pin_oe
	) else $error("pin driven during crystal oscillator mode");

	a_cpu_clock_out: assert property ( // RQ11
		(!crystal && !cpu_clock_out_config) |=> (reference_clock_pin_oe && pin_cpu_q)
	) else $error("cpu clock-out not given the pin");

	a_internal_run: assert property ( // RQ12
		(ctrl_q.en && !sleep && (crystal || !cpu_clock_out_config)) [*2] |-> (state_q == rcd_pkg::RCD_RUN)
	) else $error("generator stopped although only the pin is unavailable");

	a_sleep_hold: assert property ( // RQ13
		(sleep && state_q != rcd_pkg::RCD_OFF) |=> ($stable(wave_q) && $stable(cnt_q)) [*2]
	) else $error("generator moved during sleep");

endmodule : rcd_top

// *** tb/rcd_line_watch.sv ***
module rcd_line_watch (
	// clock
	input wire logic pclk,
	// watched line and its driver enable
	input wire logic line_out,
	input wire logic line_oe,
	// window control and result
	input wire logic clr,
	output logic [15:0] hi_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	logic level;

	// a released pin sits on the board pull-down, so it reads low, never the last value
	assign level = line_oe ? line_out : 1'b0;

	// sample mid high phase so an undivided pass-through counts as high
	always @(posedge pclk) begin
		#12;
		if (clr)
			hi_cnt = 16'h0000;
		else if (level === 1'b1)
			hi_cnt = hi_cnt + 16'h0001;
	end
endmodule : rcd_line_watch

// *** tb/reference_clock_divider_test.sv ***
module reference_clock_divider_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic cfg, lp, xt, hs, sleep, instr_clock, mod, pin, pin_oe, slew, clr;
	logic [1:0] ic = 2'h0;
	logic [15:0] pin_cnt, mod_cnt;
	int n_mismatch, cmp_count;

	rcd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_clock_out_config(cfg), .low_power_crystal_mode(lp), .crystal_mode(xt),
		.high_speed_crystal_mode(hs), .sleep(sleep), .instr_clock(instr_clock),
		.refclk_to_modulator(mod), .reference_clock_pin_out(pin), .reference_clock_pin_oe(pin_oe),
		.refclk_slew_limit_enable(slew));
	rcd_line_watch pin_w (.pclk(pclk), .line_out(pin), .line_oe(pin_oe), .clr(clr), .hi_cnt(pin_cnt));
	rcd_line_watch mod_w (.pclk(pclk), .line_out(mod), .line_oe(1'b1), .clr(clr), .hi_cnt(mod_cnt));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// instruction clock at a quarter of pclk, high two cycles of four
	always @(posedge pclk) begin
		ic <= ic + 2'h1;
		instr_clock <= ic[1];
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; pready, prdata and pslverr are taken at the rising edge
	// that completes the access, and only then is the request released
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20)
			n_mismatch++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// settle past the longest period, then count high samples over 256 cycles
	task window;
		repeat (260) @(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (255) @(posedge pclk);
		#20;
	endtask : window

	function int exp_hi(input int dv, input int dc);
		int r;
		int h;
		r = 1 << dv;
		h = r * dc / 4;
		if (h < 1)
			h = 1;
		return (dc == 0) ? 0 : 256 / r * h;
	endfunction : exp_hi

	task report_and_stop;
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	initial begin
		#(40000 * 50);
		n_mismatch++;
		report_and_stop;
	end

	initial begin
		{presetn, psel, penable, pwrite, lp, xt, hs, sleep, clr} = '0;
		{paddr, pwdata} = '0;
		cfg = 1'b1;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, rcd_pkg::RCD_CTRL_OFFSET, 32'h0);
		chk(rd, 32'h30);
		chk(slew, 1'b1);
		chk(pin_oe, 1'b0);
		apb(1'b0, 8'h0c, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		apb(1'b1, rcd_pkg::RCD_CTRL_OFFSET, 32'h0);
		repeat (2) @(posedge pclk);
		chk(slew, 1'b0);
		$display("test reset and registers done");
		// every divider and duty code, pin and modulator alike
		for (int dv = 0; dv < 8; dv++) begin
			for (int dc = 0; dc < 4; dc++) begin
				apb(1'b1, rcd_pkg::RCD_CTRL_OFFSET, {24'h0, 3'b110, dc[1:0], dv[2:0]});
				window;
				chk(pin_cnt, exp_hi(dv, dc));
				chk(mod_cnt, exp_hi(dv, dc));
			end
		end
		$display("test sweep done");
		apb(1'b1, rcd_pkg::RCD_CTRL_OFFSET, 32'h93);
		window;
		chk({pin_oe, pin_cnt}, 17'h0);
		chk(mod_cnt, 128);
		apb(1'b1, rcd_pkg::RCD_CTRL_OFFSET, 32'h53);
		window;
		chk({pin_cnt, mod_cnt}, 32'h0);
		$display("test enables done");
		apb(1'b1, rcd_pkg::RCD_CTRL_OFFSET, 32'hd3);
		for (int k = 0; k < 3; k++) begin
			@(posedge pclk);
			{lp, xt, hs} <= 3'b100 >> k;
			window;
			chk(pin_oe, 1'b0);
			chk(mod_cnt, 128);
		end
		@(posedge pclk);
		{lp, xt, hs} <= 3'b000;
		cfg <= 1'b0;
		window;
		chk({pin_oe, pin_cnt}, 17'h10080);
		chk(mod_cnt, 128);
		apb(1'b0, rcd_pkg::RCD_STATUS_OFFSET, 32'h0);
		chk(rd & 32'h1d, 32'h0d);
		@(posedge pclk);
		cfg <= 1'b1;
		$display("test pin conflicts done");
		@(posedge pclk);
		sleep <= 1'b1;
		window;
		chk((mod_cnt == 16'h0) || (mod_cnt == 16'h100), 1'b1);
		chk((pin_cnt == 16'h0) || (pin_cnt == 16'h100), 1'b1);
		apb(1'b0, rcd_pkg::RCD_STATUS_OFFSET, 32'h0);
		chk(rd & 32'h1d, 32'h14);
		@(posedge pclk);
		sleep <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, rcd_pkg::RCD_CTRL_OFFSET, 32'h0);
		chk(rd, 32'h30);
		window;
		chk(mod_cnt, 0);
		$display("test sleep and reset done");
		report_and_stop;
	end
endmodule : reference_clock_divider_test
